// ==== core/wocr_clkout_div.sv ====
module wocr_clkout_div
	import wocr_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Source ticks
	input wire logic xtal_tick_i,
	input wire logic bus_tick_i,
	// Configuration
	input wire logic source_sel_i,
	input wire wocr_clkdiv_e div_sel_i,
	input wire logic dir_out_i,
	// Pin
	output logic clkout_o,
	output logic clkout_oe_o
);

	typedef struct packed {
		logic [1:0] cnt;
		logic level;
		logic oe;
	} wocr_cko_s;

	wocr_cko_s st_reg;
	wocr_cko_s st_next;
	logic tick;
	logic [1:0] limit;

	// ****************************************
	// Divider
	// ****************************************
	// Source pick, divide ratio and pin gating
	always_comb begin
		st_next = st_reg;
		tick = source_sel_i ? xtal_tick_i : bus_tick_i;
		case (div_sel_i)
			CLKOUT_DIV1: limit = 2'h0;
			CLKOUT_DIV2: limit = 2'h1;
			CLKOUT_DIV4: limit = 2'h3;
			default: limit = 2'h0;
		endcase
		if (div_sel_i == CLKOUT_OFF) begin
			st_next.cnt = 2'h0;
			st_next.level = 1'b0;
		end else if (tick) begin
			if (st_reg.cnt >= limit) begin
				st_next.cnt = 2'h0;
				st_next.level = ~st_reg.level;
			end else begin
				st_next.cnt = st_reg.cnt + 2'h1;
			end
		end
		st_next.oe = (div_sel_i != CLKOUT_OFF) && dir_out_i;
		if (!rst_n_i) begin
			st_next = '0;
		end
	end

	// State register
	always_ff @(posedge sys_clk_i) begin
		st_reg <= st_next;
	end

	assign clkout_o = st_reg.level;
	assign clkout_oe_o = st_reg.oe;

	// ****************************************
	// Checks
	// ****************************************
	a_clkout_off_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		div_sel_i == CLKOUT_OFF |=> !clkout_oe_o && !clkout_o)
		else $error("clock output active while disabled");
	a_clkout_dir_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!dir_out_i |=> !clkout_oe_o)
		else $error("clock output driven with direction bit clear");

endmodule // wocr_clkout_div

// ==== core/wocr_config_regs.sv ====
// Functional notes
// - One write per register after each reset; both readable; consecutive addresses.
// - Reset clears option bits except documented defaults and power-on-only bits.
// - CAN enable and supply mode bits: written once per power-on, cleared only by it.
// - Divide select 00 off, 01 undivided, 10 divide by 2, 11 divide by 4.
// - Clock-output pin is gated by its data-direction bit.
// - Clock-output source: crystal when set, bus clock when clear.
// - CAN enable bit enables the CAN controller and hands it two port pins.
// - Timebase bit inserts extra divide-by-128 prescaler when set.
// - Oscillator keeps running in stop when set; stops when clear.
// - Serial baud source: bus clock when set (default), oscillator when clear.
// - Watchdog rate: 8176 cycles when set, 262128 when clear.
// - Low-voltage monitor runs in stop when set and not powered down.
// - Low-voltage reset disable bit blocks monitor resets when set.
// - Low-voltage power disable bit powers the monitor down when set.
// - Low-voltage mode: 5 V trip points when set, 3 V when clear.
// - Stop exit waits 32 oscillator cycles when set, 4096 when clear.
// - Stop exit by any reset always uses the long delay.
// - Stop instruction is illegal opcode when disabled, executes when enabled.
// - Watchdog disable bit turns the watchdog off when set.
// - A disabled stop instruction raises an illegal-opcode reset.
//
// Local design decision: register access over Avalon-MM.
module wocr_config_regs
	import wocr_pkg::*;
(
	// Clock and resets
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic power_on_reset_n_i,
	// Avalon-MM slave
	input wire logic [BUS_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Clock ticks and pin direction
	input wire logic xtal_tick_i,
	input wire logic bus_tick_i,
	input wire logic clkout_dir_out_i,
	// Stop control from the core
	input wire logic stop_insn_i,
	input wire logic stop_wake_i,
	input wire logic stop_wake_by_reset_i,
	// Clock-output pin
	output logic clkout_o,
	output logic clkout_oe_o,
	// Option outputs to other units
	output logic can_enable_o,
	output logic timebase_prescale_select_o,
	output logic osc_run_in_stop_o,
	output logic serial_baud_source_o,
	output logic watchdog_disable_o,
	output logic [17:0] watchdog_timeout_cycles_o,
	output logic lowvolt_stop_active_o,
	output logic lowvolt_reset_disable_o,
	output logic lowvolt_power_disable_o,
	output logic lowvolt_supply_mode_o,
	// Stop handling
	output logic stop_execute_o,
	output logic illegal_opcode_reset_o,
	output logic stop_recovery_busy_o,
	output logic stop_recovery_done_o
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		wocr_opt_two_s opt_two;
		wocr_opt_one_s opt_one;
		logic two_locked;
		logic one_locked;
		logic two_por_locked;
		logic one_por_locked;
		logic waitreq;
		logic [31:0] rdata;
		logic stop_exec;
		logic illegal_rst;
		logic lv_stop_active;
		logic [17:0] wdog_cyc;
	} wocr_top_s;

	localparam wocr_top_s POR_STATE = '{
		opt_two: wocr_opt_two_s'(OPT_TWO_RESET),
		opt_one: wocr_opt_one_s'(OPT_ONE_RESET),
		two_locked: 1'b0,
		one_locked: 1'b0,
		two_por_locked: 1'b0,
		one_por_locked: 1'b0,
		waitreq: 1'b1,
		rdata: 32'h0000_0000,
		stop_exec: 1'b0,
		illegal_rst: 1'b0,
		lv_stop_active: 1'b0,
		wdog_cyc: WDOG_SLOW_CYC
	};

	wocr_top_s st_reg;
	wocr_top_s st_next;
	logic hit_two;
	logic hit_one;
	logic sys_rst_n;

	// ****************************************
	// Helpers
	// ****************************************
	// Word decode of a byte address against a register index
	function automatic logic addr_hits(input logic [BUS_ADDR_W-1:0] a, input logic [5:0] idx);
		return (a[1:0] == 2'h0) && (a[BUS_ADDR_W-1:2] == idx);
	endfunction

	// Replace the masked bits of old with new
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nv,
		input logic [7:0] mask);
		return (old & ~mask) | (nv & mask);
	endfunction

	assign hit_two = addr_hits(avs_address_i, OPT_TWO_IDX);
	assign hit_one = addr_hits(avs_address_i, OPT_ONE_IDX);
	assign sys_rst_n = reset_n_i & power_on_reset_n_i;

	// ****************************************
	// Register file and bus slave
	// ****************************************
	// One wait state per access, write-once latches, stop decode
	always_comb begin
		st_next = st_reg;
		st_next.stop_exec = 1'b0;
		st_next.illegal_rst = 1'b0;
		if ((avs_read_i || avs_write_i) && st_reg.waitreq) begin
			st_next.waitreq = 1'b0;
			st_next.rdata = 32'h0000_0000;
			if (avs_read_i && hit_two) begin
				st_next.rdata = {24'h00_0000, st_reg.opt_two};
			end else if (avs_read_i && hit_one) begin
				st_next.rdata = {24'h00_0000, st_reg.opt_one};
			end
		end else if (!st_reg.waitreq) begin
			st_next.waitreq = 1'b1;
			if (avs_write_i && avs_byteenable_i[0] && hit_two) begin
				if (!st_reg.two_locked) begin
					st_next.opt_two = wocr_opt_two_s'(merge(st_reg.opt_two,
						avs_writedata_i[7:0], OPT_TWO_WR_MASK & ~OPT_TWO_POR_MASK));
					st_next.two_locked = 1'b1;
				end
				if (!st_reg.two_por_locked) begin
					st_next.opt_two = wocr_opt_two_s'(merge(st_next.opt_two,
						avs_writedata_i[7:0], OPT_TWO_POR_MASK));
					st_next.two_por_locked = 1'b1;
				end
			end
			if (avs_write_i && avs_byteenable_i[0] && hit_one) begin
				if (!st_reg.one_locked) begin
					st_next.opt_one = wocr_opt_one_s'(merge(st_reg.opt_one,
						avs_writedata_i[7:0], OPT_ONE_WR_MASK & ~OPT_ONE_POR_MASK));
					st_next.one_locked = 1'b1;
				end
				if (!st_reg.one_por_locked) begin
					st_next.opt_one = wocr_opt_one_s'(merge(st_next.opt_one,
						avs_writedata_i[7:0], OPT_ONE_POR_MASK));
					st_next.one_por_locked = 1'b1;
				end
			end
		end
		if (stop_insn_i) begin
			if (st_reg.opt_one.stop_enable) begin
				st_next.stop_exec = 1'b1;
			end else begin
				st_next.illegal_rst = 1'b1;
			end
		end
		if (!power_on_reset_n_i) begin
			st_next = POR_STATE;
		end else if (!reset_n_i) begin
			st_next = POR_STATE;
			st_next.opt_two = wocr_opt_two_s'(merge(OPT_TWO_RESET, st_reg.opt_two,
				OPT_TWO_POR_MASK));
			st_next.opt_one = wocr_opt_one_s'(merge(OPT_ONE_RESET, st_reg.opt_one,
				OPT_ONE_POR_MASK));
			st_next.two_por_locked = st_reg.two_por_locked;
			st_next.one_por_locked = st_reg.one_por_locked;
		end
		st_next.lv_stop_active = st_next.opt_one.lowvolt_run_in_stop
			& ~st_next.opt_one.lowvolt_power_disable;
		st_next.wdog_cyc = st_next.opt_one.watchdog_rate_select ? WDOG_FAST_CYC : WDOG_SLOW_CYC;
	end

	// State register
	always_ff @(posedge sys_clk_i) begin
		st_reg <= st_next;
	end

	// ****************************************
	// Option outputs
	// ****************************************
	// Bus answer
	assign avs_readdata_o = st_reg.rdata;
	assign avs_waitrequest_o = st_reg.waitreq;
	assign can_enable_o = st_reg.opt_two.can_enable;
	assign timebase_prescale_select_o = st_reg.opt_two.timebase_prescale_select;
	assign osc_run_in_stop_o = st_reg.opt_two.osc_run_in_stop;
	assign serial_baud_source_o = st_reg.opt_two.serial_baud_source;
	assign watchdog_disable_o = st_reg.opt_one.watchdog_disable;
	assign watchdog_timeout_cycles_o = st_reg.wdog_cyc;
	assign lowvolt_stop_active_o = st_reg.lv_stop_active;
	assign lowvolt_reset_disable_o = st_reg.opt_one.lowvolt_reset_disable;
	assign lowvolt_power_disable_o = st_reg.opt_one.lowvolt_power_disable;
	assign lowvolt_supply_mode_o = st_reg.opt_one.lowvolt_supply_mode;
	assign stop_execute_o = st_reg.stop_exec;
	assign illegal_opcode_reset_o = st_reg.illegal_rst;

	// ****************************************
	// Clock output and stop recovery
	// ****************************************
	// Divided clock onto the shared port pin
	wocr_clkout_div u_clkout (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(sys_rst_n),
		.xtal_tick_i(xtal_tick_i),
		.bus_tick_i(bus_tick_i),
		.source_sel_i(st_reg.opt_two.clkout_source_select),
		.div_sel_i(wocr_clkdiv_e'({st_reg.opt_two.clkout_divide_sel_hi,
			st_reg.opt_two.clkout_divide_sel_lo})),
		.dir_out_i(clkout_dir_out_i),
		.clkout_o(clkout_o),
		.clkout_oe_o(clkout_oe_o)
	);

	// Stop exit delay, reset only at power-on so a reset exit can count
	wocr_stop_recovery #(
		.SHORT_CYC(SHORT_RECOVERY_CYC),
		.LONG_CYC(LONG_RECOVERY_CYC)
	) u_recovery (
		.sys_clk_i(sys_clk_i),
		.por_n_i(power_on_reset_n_i),
		.osc_tick_i(xtal_tick_i),
		.wake_i(stop_wake_i),
		.wake_by_reset_i(stop_wake_by_reset_i),
		.short_sel_i(st_reg.opt_one.short_stop_recovery),
		.busy_o(stop_recovery_busy_o),
		.done_o(stop_recovery_done_o)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!sys_rst_n);

	a_wait_one_cycle: assert property (
		((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o ##1
		avs_waitrequest_o)
		else $error("waitrequest not low for exactly one cycle");
	a_read_two_data: assert property (
		(avs_read_i && avs_waitrequest_o && hit_two)
		|=> avs_readdata_o == {24'h00_0000, $past(st_reg.opt_two)})
		else $error("read of second options register returned wrong data");
	a_sys_reset_clear: assert property (disable iff (!power_on_reset_n_i)
		!reset_n_i |=> (st_reg.opt_one & ~OPT_ONE_POR_MASK) == OPT_ONE_RESET
		&& (st_reg.opt_two & ~OPT_TWO_POR_MASK) == OPT_TWO_RESET)
		else $error("system reset left option bits set");
	a_por_bits_keep: assert property (disable iff (!power_on_reset_n_i)
		!reset_n_i |=> can_enable_o == $past(can_enable_o)
		&& lowvolt_supply_mode_o == $past(lowvolt_supply_mode_o))
		else $error("system reset changed a power-on-only bit");
	a_write_ignored: assert property (
		(avs_write_i && !avs_waitrequest_o && hit_two && st_reg.two_locked)
		|=> ((st_reg.opt_two ^ $past(st_reg.opt_two)) & ~OPT_TWO_POR_MASK) == 8'h00)
		else $error("locked register changed on write");
	a_stop_illegal: assert property (
		(stop_insn_i && !st_reg.opt_one.stop_enable)
		|=> illegal_opcode_reset_o && !stop_execute_o)
		else $error("disabled stop did not raise illegal opcode reset");
	a_stop_execute: assert property (
		(stop_insn_i && st_reg.opt_one.stop_enable)
		|=> stop_execute_o && !illegal_opcode_reset_o)
		else $error("enabled stop did not execute");
	a_lowvolt_stop: assert property (
		lowvolt_stop_active_o == (st_reg.opt_one.lowvolt_run_in_stop
		&& !lowvolt_power_disable_o))
		else $error("monitor stop enable mismatched");
	a_wdog_rate: assert property (
		$changed(st_reg.opt_one.watchdog_rate_select) |-> watchdog_timeout_cycles_o ==
		(st_reg.opt_one.watchdog_rate_select ? WDOG_FAST_CYC : WDOG_SLOW_CYC))
		else $error("watchdog timeout does not follow rate bit");

	c_write_two: cover property (avs_write_i && !avs_waitrequest_o && hit_two);
	c_illegal_stop: cover property (illegal_opcode_reset_o);
	c_stop_exec: cover property (stop_execute_o);
	c_recovery_done: cover property (stop_recovery_done_o);

endmodule // wocr_config_regs

// ==== core/wocr_stop_recovery.sv ====
module wocr_stop_recovery
	import wocr_pkg::*;
#(
	parameter int unsigned SHORT_CYC = SHORT_RECOVERY_CYC,
	parameter int unsigned LONG_CYC = LONG_RECOVERY_CYC
) (
	// Clock and power-on reset
	input wire logic sys_clk_i,
	input wire logic por_n_i,
	// Wake request
	input wire logic osc_tick_i,
	input wire logic wake_i,
	input wire logic wake_by_reset_i,
	input wire logic short_sel_i,
	// Status
	output logic busy_o,
	output logic done_o
);

	localparam int unsigned CW = $clog2(LONG_CYC + 1);

	if (SHORT_CYC < 1 || SHORT_CYC >= LONG_CYC) begin : g_bad_counts
		$error("recovery counts out of range");
	end

	typedef struct packed {
		wocr_rec_e state;
		logic [CW-1:0] cnt;
		logic done;
	} wocr_rec_s;

	wocr_rec_s st_reg;
	wocr_rec_s st_next;

	// ****************************************
	// Recovery counter
	// ****************************************
	// Load on wake, count oscillator ticks, pulse at end
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		case (st_reg.state)
			REC_IDLE: begin
				if (wake_i) begin
					st_next.state = REC_COUNT;
					if (short_sel_i && !wake_by_reset_i) begin
						st_next.cnt = CW'(SHORT_CYC);
					end else begin
						st_next.cnt = CW'(LONG_CYC);
					end
				end
			end
			REC_COUNT: begin
				if (osc_tick_i) begin
					st_next.cnt = st_reg.cnt - CW'(1);
					if (st_reg.cnt == CW'(1)) begin
						st_next.state = REC_IDLE;
						st_next.done = 1'b1;
					end
				end
			end
			default: st_next.state = REC_IDLE;
		endcase
		if (!por_n_i) begin
			st_next = '0;
		end
	end

	// State register
	always_ff @(posedge sys_clk_i) begin
		st_reg <= st_next;
	end

	assign busy_o = (st_reg.state == REC_COUNT);
	assign done_o = st_reg.done;

	// ****************************************
	// Checks
	// ****************************************
	a_reset_exit_long: assert property (@(posedge sys_clk_i) disable iff (!por_n_i)
		(st_reg.state == REC_IDLE && wake_i && wake_by_reset_i)
		|=> st_reg.cnt == CW'(LONG_CYC))
		else $error("reset exit did not load long delay");
	a_short_load: assert property (@(posedge sys_clk_i) disable iff (!por_n_i)
		(st_reg.state == REC_IDLE && wake_i && !wake_by_reset_i)
		|=> st_reg.cnt == ($past(short_sel_i) ? CW'(SHORT_CYC) : CW'(LONG_CYC)))
		else $error("wrong stop recovery delay loaded");

endmodule // wocr_stop_recovery

// ==== pkg/wocr_pkg.sv ====
package wocr_pkg;

	// ****************************************
	// Register map
	// ****************************************
	// Printed offsets are word indices; byte address is four times the index
	localparam int unsigned BUS_ADDR_W = 8;
	localparam logic [5:0] OPT_TWO_IDX = 6'h1E;
	localparam logic [5:0] OPT_ONE_IDX = 6'h1F;

	// Field layout of system_options_two
	typedef struct packed {
		logic clkout_source_select;
		logic clkout_divide_sel_hi;
		logic clkout_divide_sel_lo;
		logic can_enable;
		logic timebase_prescale_select;
		logic osc_run_in_stop;
		logic serial_baud_source;
		logic reserved0;
	} wocr_opt_two_s;

	// Field layout of system_options_one
	typedef struct packed {
		logic watchdog_rate_select;
		logic lowvolt_run_in_stop;
		logic lowvolt_reset_disable;
		logic lowvolt_power_disable;
		logic lowvolt_supply_mode;
		logic short_stop_recovery;
		logic stop_enable;
		logic watchdog_disable;
	} wocr_opt_one_s;

	// Reset values and bit classes
	localparam logic [7:0] OPT_TWO_RESET = 8'h02;
	localparam logic [7:0] OPT_ONE_RESET = 8'h00;
	localparam logic [7:0] OPT_TWO_WR_MASK = 8'hFE;
	localparam logic [7:0] OPT_ONE_WR_MASK = 8'hFF;
	localparam logic [7:0] OPT_TWO_POR_MASK = 8'h10;
	localparam logic [7:0] OPT_ONE_POR_MASK = 8'h08;

	// ****************************************
	// Timing counts, in oscillator cycles
	// ****************************************
	localparam int unsigned SHORT_RECOVERY_CYC = 32;
	localparam int unsigned LONG_RECOVERY_CYC = 4096;
	localparam logic [17:0] WDOG_FAST_CYC = 18'd8176;
	localparam logic [17:0] WDOG_SLOW_CYC = 18'd262128;

	// ****************************************
	// Enumerations
	// ****************************************
	typedef enum logic [1:0] {CLKOUT_OFF, CLKOUT_DIV1, CLKOUT_DIV2, CLKOUT_DIV4} wocr_clkdiv_e;
	typedef enum logic {REC_IDLE, REC_COUNT} wocr_rec_e;

endpackage

// ==== tb/wocr_config_regs_bench.sv ====
module wocr_config_regs_bench
	import wocr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// Stimulus, bus and reference model
	// ****************************************
	localparam logic [7:0] a_two = {OPT_TWO_IDX, 2'b00};
	localparam logic [7:0] a_one = {OPT_ONE_IDX, 2'b00};
	logic sys_clk_i = 1'b0, reset_n_i = 1'b0, por_n = 1'b0, xtal = 1'b0, btick = 1'b0;
	logic dir = 1'b0, stop_insn = 1'b0, wake = 1'b0, wake_rst = 1'b0;
	logic [7:0] addr;
	logic rd, wr, wait_rq, clkout, oe, can, tbs, osc, sbs, wdd, lvs, lvr, lvp, lvm;
	logic sexe, ill, busy, done, last_clk;
	logic [31:0] wdata, rdata, seed = 32'd78194;
	logic [3:0] be;
	logic [17:0] wdt;
	logic [7:0] opt [2];
	logic lock [2], plock [2];
	int tc = 0, since = 0, gap = 0, failures = 0, check_count = 0;
	wire src_tick = opt[0][7] ? xtal : btick;

	// Clock of 20 ns
	always #10 sys_clk_i = ~sys_clk_i;

	// Oscillator tick every 2nd cycle, bus tick every 3rd
	always @(posedge sys_clk_i) begin
		tc <= tc + 1;
		xtal <= (tc % 2 == 0);
		btick <= (tc % 3 == 0);
	end

	// Source ticks between two changes of the clock-output pin
	always @(posedge sys_clk_i) begin
		if (clkout !== last_clk) begin
			gap <= since;
			since <= int'(src_tick);
		end else if (src_tick) begin
			since <= since + 1;
		end
		last_clk <= clkout;
	end

	wocr_host_model host (.sys_clk_i(sys_clk_i), .avs_address_o(addr), .avs_read_o(rd),
		.avs_write_o(wr), .avs_writedata_o(wdata), .avs_byteenable_o(be),
		.avs_readdata_i(rdata), .avs_waitrequest_i(wait_rq));

	wocr_config_regs dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.power_on_reset_n_i(por_n), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_rq), .xtal_tick_i(xtal), .bus_tick_i(btick),
		.clkout_dir_out_i(dir), .stop_insn_i(stop_insn), .stop_wake_i(wake),
		.stop_wake_by_reset_i(wake_rst), .clkout_o(clkout), .clkout_oe_o(oe),
		.can_enable_o(can), .timebase_prescale_select_o(tbs), .osc_run_in_stop_o(osc),
		.serial_baud_source_o(sbs), .watchdog_disable_o(wdd), .watchdog_timeout_cycles_o(wdt),
		.lowvolt_stop_active_o(lvs), .lowvolt_reset_disable_o(lvr),
		.lowvolt_power_disable_o(lvp), .lowvolt_supply_mode_o(lvm), .stop_execute_o(sexe),
		.illegal_opcode_reset_o(ill), .stop_recovery_busy_o(busy), .stop_recovery_done_o(done));

	// Comparison and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Ends the run with the verdict
	task automatic wrap_up();
		$display("%0d checks, %0d failures", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Latch model: one write per reset, power-on bits once per power-on
	function automatic void mdl_wr(input int r, input logic [7:0] v);
		logic [7:0] pm;
		pm = r ? OPT_ONE_POR_MASK : OPT_TWO_POR_MASK;
		if (!lock[r]) opt[r] = (opt[r] & pm) | (v & ~pm & (r ? OPT_ONE_WR_MASK : OPT_TWO_WR_MASK));
		if (!plock[r]) opt[r] = (opt[r] & ~pm) | (v & pm);
		lock[r] = 1'b1;
		plock[r] = 1'b1;
	endfunction

	// Reset for 4 cycles, power-on or system only
	task automatic do_reset(input logic por);
		logic [7:0] pm, rv;
		@(posedge sys_clk_i);
		reset_n_i <= 1'b0;
		por_n <= !por;
		repeat (4) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		por_n <= 1'b1;
		for (int r = 0; r < 2; r++) begin
			pm = r ? OPT_ONE_POR_MASK : OPT_TWO_POR_MASK;
			rv = r ? OPT_ONE_RESET : OPT_TWO_RESET;
			opt[r] = por ? rv : ((opt[r] & pm) | (rv & ~pm));
			lock[r] = 1'b0;
			if (por) plock[r] = 1'b0;
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		host.xfer(1'b0, a, 8'h00, 4'hF, q);
		chk(q, exp);
	endtask

	task automatic chk_outs();
		logic [7:0] t, o;
		t = opt[0];
		o = opt[1];
		chk(32'({can, tbs, osc, sbs, lvr, lvp, lvm, wdd}), 32'({t[4:1], o[5:3], o[0]}));
		chk(32'(wdt), o[7] ? 32'd8176 : 32'd262128);
		chk(32'(lvs), 32'(o[6] & !o[4]));
	endtask

	task automatic stop_chk();
		@(posedge sys_clk_i);
		stop_insn <= 1'b1;
		@(posedge sys_clk_i);
		stop_insn <= 1'b0;
		@(negedge sys_clk_i);
		chk(32'({sexe, ill}), {30'h0, opt[1][1], !opt[1][1]});
	endtask

	// Oscillator ticks from wake to the end of recovery
	task automatic recover(input logic by_rst);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		wake <= 1'b1;
		wake_rst <= by_rst;
		@(posedge sys_clk_i);
		wake <= 1'b0;
		wake_rst <= 1'b0;
		@(negedge sys_clk_i);
		chk(32'(busy), 32'h1);
		while (done !== 1'b1 && n < 9000) begin
			if (xtal) n++;
			@(negedge sys_clk_i);
		end
		chk(32'(n), (opt[1][2] && !by_rst) ? 32'd32 : 32'd4096);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	// Cuts a hang short; the tests need about 20k cycles
	initial begin
		repeat (60000) @(posedge sys_clk_i);
		failures++;
		wrap_up();
	end

	// Eight passes over clock-output modes, stop and recovery settings
	initial begin
		logic [7:0] v2, v1;
		logic [31:0] r, q;
		do_reset(1'b1);
		rd_chk(8'h40, 32'h0);
		for (int i = 0; i < 8; i++) begin
			if (i > 0) do_reset(i == 4);
			rd_chk(a_two, {24'h0, opt[0]});
			rd_chk(a_one, {24'h0, opt[1]});
			chk_outs();
			r = $random(seed);
			v2 = {i[2:0], i < 4, r[0], i[1], r[2:1]};
			v1 = {r[7:4], i < 4, i[1], i[0], r[3]};
			host.xfer(1'b1, a_two, ~v2, 4'h0, q);
			host.load_opts(v2, v1);
			mdl_wr(0, v2);
			mdl_wr(1, v1);
			host.load_opts(~v2, ~v1);
			rd_chk(a_two, {24'h0, opt[0]});
			rd_chk(a_one, {24'h0, opt[1]});
			dir <= r[8];
			repeat (80) @(negedge sys_clk_i);
			chk_outs();
			if (opt[0][6:5] == 2'd0) begin
				chk(32'({clkout, oe}), 32'h0);
			end else begin
				chk(32'(gap), 32'(1 << (opt[0][6:5] - 2'd1)));
				chk(32'(oe), 32'(dir));
			end
			stop_chk();
			if (i[1] || i == 0) recover(1'b0);
			if (i == 2) recover(1'b1);
			$display("test %0d done", i);
		end
		wrap_up();
	end
endmodule // wocr_config_regs_bench

// ==== tb/wocr_host_model.sv ====
module wocr_host_model
	import wocr_pkg::*;
(
	// Clock
	input wire logic sys_clk_i,
	// Avalon-MM master side
	output logic [BUS_ADDR_W-1:0] avs_address_o,
	output logic avs_read_o,
	output logic avs_write_o,
	output logic [31:0] avs_writedata_o,
	output logic [3:0] avs_byteenable_o,
	input wire logic [31:0] avs_readdata_i,
	input wire logic avs_waitrequest_i
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// Bus cycles of the configuring software
	// ****************************************
	// Idle bus at time zero
	initial begin
		avs_address_o = '0;
		avs_read_o = 1'b0;
		avs_write_o = 1'b0;
		avs_writedata_o = '0;
		avs_byteenable_o = '0;
	end

	// One cycle, held until waitrequest is sampled low
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data,
		input logic [3:0] be, output logic [31:0] rdata);
		@(posedge sys_clk_i);
		avs_address_o <= addr;
		avs_read_o <= !wr;
		avs_write_o <= wr;
		avs_writedata_o <= {24'h0, data};
		avs_byteenable_o <= be;
		// Waits for the answer; only the bench watchdog ends a hang
		do begin
			@(posedge sys_clk_i);
		end while (avs_waitrequest_i !== 1'b0);
		rdata = avs_readdata_i;
		avs_read_o <= 1'b0;
		avs_write_o <= 1'b0;
	endtask

	task automatic load_opts(input logic [7:0] two, input logic [7:0] one);
		logic [31:0] q;
		if (!two[2]) one[2] = 1'b0;
		xfer(1'b1, {OPT_TWO_IDX, 2'b00}, two, 4'hF, q);
		xfer(1'b1, {OPT_ONE_IDX, 2'b00}, one, 4'hF, q);
	endtask
endmodule // wocr_host_model
